//--- hw/rpt_defines.svh
// Offsets, field values, reset values and timing constants of the protocol timer unit
`ifndef RPT_DEFINES_SVH
`define RPT_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RPT_ADR_CTRL      8'h00
`define RPT_ADR_MRT       8'h04
`define RPT_ADR_NRT_HI    8'h08
`define RPT_ADR_NRT_LO    8'h0c
`define RPT_ADR_GPT       8'h10
`define RPT_ADR_WUT       8'h14
`define RPT_ADR_CMD       8'h18
`define RPT_ADR_STATUS    8'h1c

// ----------------------------------------------------------------
// Direct command codes, written to the command register
// ----------------------------------------------------------------
`define RPT_CMD_CLEAR     8'h01
`define RPT_CMD_START_MRT 8'h02
`define RPT_CMD_START_NRT 8'h03
`define RPT_CMD_START_GPT 8'h04
`define RPT_CMD_START_WUT 8'h05

// ----------------------------------------------------------------
// General purpose timer trigger sources
// ----------------------------------------------------------------
`define RPT_GPT_TRIG_NONE 2'h0
`define RPT_GPT_TRIG_SOF  2'h1
`define RPT_GPT_TRIG_EOF  2'h2
`define RPT_GPT_TRIG_FOFF 2'h3

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define RPT_CTRL_W        9
`define RPT_CTRL_RST      9'h000
`define RPT_MRT_RST       8'h00
`define RPT_NRT_RST       16'h0000
`define RPT_GPT_RST       16'h0000

// ----------------------------------------------------------------
// Timing: carrier steps in carrier periods, wake-up steps in ms
// ----------------------------------------------------------------
`define RPT_STEP_FINE     64
`define RPT_STEP_LPIT     512
`define RPT_STEP_COARSE   4096
`define RPT_CLK_HZ        10000000
`define RPT_WU_STEP_MS    10
`define RPT_WU_MIN_MS     10
`define RPT_WU_MAX_MS     800
`define RPT_WU_DEF_MS     100

`endif

//--- hw/rpt_pkg.sv
// Types shared by the protocol timer unit
package rpt_pkg;

	// Control register layout, most significant field first
	typedef struct packed {
		logic [1:0] gptTrig;
		logic       nrtStep;
		logic       nrtEmv;
		logic       squelchEn;
		logic       lowPower;
		logic       wakeMode;
		logic       lpInitTarget;
		logic       p2pActive;
	} rpt_ctrl_t;

	// Framing and field events; pulses except replyActive
	typedef struct packed {
		logic txEnd;
		logic rxStart;
		logic rxEnd;
		logic replyActive;
		logic peerFieldOn;
		logic peerFieldOff;
	} rpt_evt_t;

	// Carrier step ticks from the prescaler
	typedef struct packed {
		logic fine;
		logic lpit;
		logic coarse;
	} rpt_tick_t;

endpackage

//--- hw/rpt_fc_prescaler.sv
// Carrier period prescaler: step ticks of 64, 512 and 4096 carrier periods
`include "rpt_defines.svh"
module rpt_fc_prescaler
	import rpt_pkg::*;
#(
	parameter int CW = 12
)
(
	input  wire logic      clk_sys,
	input  wire logic      arst_n,
	input  wire logic      carrierTick,
	input  wire logic      enable,
	output rpt_tick_t      ticks
);
	localparam logic [CW-1:0] FINE_M   = CW'(`RPT_STEP_FINE - 1);
	localparam logic [CW-1:0] LPIT_M   = CW'(`RPT_STEP_LPIT - 1);
	localparam logic [CW-1:0] COARSE_M = CW'(`RPT_STEP_COARSE - 1);

	logic [CW-1:0] cnt;
	rpt_tick_t     next_ticks;

	// Tick fires on the carrier period that closes each step
	assign next_ticks.fine   = enable & carrierTick & ((cnt & FINE_M) == FINE_M);
	assign next_ticks.lpit   = enable & carrierTick & ((cnt & LPIT_M) == LPIT_M);
	assign next_ticks.coarse = enable & carrierTick & ((cnt & COARSE_M) == COARSE_M);

	// Free running count; held at zero while the crystal is stopped
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt   <= '0;
			ticks <= '0;
		end
		else
		begin
			ticks <= next_ticks;
			if (!enable)
				cnt <= '0;
			else if (carrierTick)
				cnt <= cnt + CW'(1);
		end
	end
endmodule

//--- hw/rpt_timers.sv
// Reader protocol timer unit with a classic Wishbone register slave
//
// What this block does
// - Clear command halts every timer except the wake-up timer.
// - With unconditional expiry set, Clear leaves the no-response timer running.
// - End of transmit frame starts the no-response timer, and the mask receive timer outside active peer mode.
// - Receive window stays low while the mask receive timer runs.
// - Squelch follows the mask timer when enabled; mask expiry raises no flag.
// - In active peer mode the peer field switching on starts the mask timer.
// - Low power target mode: command starts mask timer, step 512 carrier periods.
// - No-response count from two byte registers; step of 64 or 4096 periods.
// - Expiry before reply start flags and closes window; reply start stops silently.
// - Unconditional expiry always flags; window closes only when no reply active.
// - Start no-response command restarts the timer; ignored in active peer mode.
// - In active peer mode, expiry before peer field on raises the flag.
// - No-response expiry sets its own dedicated status flag.
// - General timer triggers on SOF, EOF or, in active peer mode only, peer field off; every expiry flags.
// - Start general timer command starts or restarts the general timer.
// - Start wake-up command is ignored while in wake-up mode.
// - Wake-up command runs the RC clock and sets the wake-up flag on expiry.
// - In low power only the wake-up timer runs; carrier timers are held off.
// - Wake-up timeout spans 10 to 800 ms, 100 ms after reset.
`include "rpt_defines.svh"
module rpt_timers
	import rpt_pkg::*;
#(
	parameter int AW             = 8,
	parameter int WU_STEP_CYCLES = `RPT_CLK_HZ / 1000 * `RPT_WU_STEP_MS
)
(
	input  wire logic          clk_sys,
	input  wire logic          arst_n,
	input  wire logic          cyc_i,
	input  wire logic          stb_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] adr_i,
	input  wire logic [31:0]   dat_i,
	input  wire logic [3:0]    sel_i,
	output logic      [31:0]   dat_o,
	output logic               ack_o,
	input  wire logic          carrierTick,
	input  rpt_evt_t           ev,
	output logic               rxOn,
	output logic               squelchOn,
	output logic               rcOscEn
);
	localparam int WUW = $clog2(WU_STEP_CYCLES + 1);
	localparam logic [7:0] WU_MIN = 8'(`RPT_WU_MIN_MS / `RPT_WU_STEP_MS);
	localparam logic [7:0] WU_MAX = 8'(`RPT_WU_MAX_MS / `RPT_WU_STEP_MS);
	localparam logic [7:0] WU_RST = 8'(`RPT_WU_DEF_MS / `RPT_WU_STEP_MS);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Byte lane merge of a write into a register of up to 32 bits
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (wd & m);
	endfunction

	// Sticky flag: a set in the clear cycle wins
	function automatic logic stickyNext(input logic cur, input logic set,
		input logic clr);
		return set | (cur & ~clr);
	endfunction

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	rpt_ctrl_t   ctrl;
	logic [7:0]  mrtCfg;
	logic [7:0]  nrtHi;
	logic [7:0]  nrtLo;
	logic [15:0] gptCfg;
	logic [7:0]  wutCfg;

	// A write takes effect on the edge that samples ack high; read data is captured on the edge that raises ack
	wire         acc       = cyc_i & stb_i & ack_o;
	wire         wrAcc     = acc & we_i;
	wire         selCtrl   = (adr_i == `RPT_ADR_CTRL);
	wire         selMrt    = (adr_i == `RPT_ADR_MRT);
	wire         selNrtHi  = (adr_i == `RPT_ADR_NRT_HI);
	wire         selNrtLo  = (adr_i == `RPT_ADR_NRT_LO);
	wire         selGpt    = (adr_i == `RPT_ADR_GPT);
	wire         selWut    = (adr_i == `RPT_ADR_WUT);
	wire         selCmd    = (adr_i == `RPT_ADR_CMD);
	wire         selStatus = (adr_i == `RPT_ADR_STATUS);
	wire [31:0]  ctrlMerge = laneMerge(32'(ctrl), dat_i, sel_i);
	wire [31:0]  mrtMerge  = laneMerge(32'(mrtCfg), dat_i, sel_i);
	wire [31:0]  hiMerge   = laneMerge(32'(nrtHi), dat_i, sel_i);
	wire [31:0]  loMerge   = laneMerge(32'(nrtLo), dat_i, sel_i);
	wire [31:0]  gptMerge  = laneMerge(32'(gptCfg), dat_i, sel_i);
	wire [31:0]  wutMerge  = laneMerge(32'(wutCfg), dat_i, sel_i);
	wire [7:0]   wutWr     = wutMerge[7:0];
	// Wake-up setting is held inside the supported span
	wire [7:0]   wutClamp  = (wutWr < WU_MIN) ? WU_MIN :
		(wutWr > WU_MAX) ? WU_MAX : wutWr;

	// Direct commands decode from byte lane 0 of a command write
	wire         cmdWr     = wrAcc & selCmd & sel_i[0];
	wire         cmdClear  = cmdWr & (dat_i[7:0] == `RPT_CMD_CLEAR);
	wire         cmdMrt    = cmdWr & (dat_i[7:0] == `RPT_CMD_START_MRT);
	wire         cmdNrt    = cmdWr & (dat_i[7:0] == `RPT_CMD_START_NRT);
	wire         cmdGpt    = cmdWr & (dat_i[7:0] == `RPT_CMD_START_GPT);
	wire         cmdWut    = cmdWr & (dat_i[7:0] == `RPT_CMD_START_WUT);
	wire         flagClr   = wrAcc & selStatus & sel_i[0];

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			ack_o <= 1'b0;
		else
			ack_o <= cyc_i & stb_i & ~ack_o;
	end

	// Configuration registers; counts are only safe to change while idle
	// idle reprogramming only
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl   <= rpt_ctrl_t'(`RPT_CTRL_RST);
			mrtCfg <= `RPT_MRT_RST;
			nrtHi  <= 8'(`RPT_NRT_RST >> 8);
			nrtLo  <= 8'(`RPT_NRT_RST);
			gptCfg <= `RPT_GPT_RST;
			wutCfg <= WU_RST;
		end
		else if (wrAcc)
		begin
			if (selCtrl)
				ctrl <= rpt_ctrl_t'(ctrlMerge[`RPT_CTRL_W-1:0]);
			if (selMrt)
				mrtCfg <= mrtMerge[7:0];
			if (selNrtHi)
				nrtHi <= hiMerge[7:0];
			if (selNrtLo)
				nrtLo <= loMerge[7:0];
			if (selGpt)
				gptCfg <= gptMerge[15:0];
			// wake-up span 10 to 800 ms
			if (selWut)
				wutCfg <= wutClamp;
		end
	end

	// ----------------------------------------------------------------
	// Carrier prescaler
	// ----------------------------------------------------------------
	rpt_tick_t ticks;

	rpt_fc_prescaler u_prescaler (
		.clk_sys     (clk_sys),
		.arst_n      (arst_n),
		.carrierTick (carrierTick),
		.enable      (~ctrl.lowPower),
		.ticks       (ticks)
	);

	// ----------------------------------------------------------------
	// Mask receive timer
	// ----------------------------------------------------------------
	logic [7:0] mrtCnt;
	logic       mrtRun;
	logic       mrtSlow;

	// starts at end of transmit frame, or at peer field on in active peer mode
	wire mrtHwStart = ctrl.p2pActive ? ev.peerFieldOn : ev.txEnd;
	// command start in low power target mode
	wire mrtStart   = ~ctrl.lowPower & (mrtHwStart | cmdMrt);
	wire mrtTick    = mrtSlow ? ticks.lpit : ticks.fine;
	wire mrtExpire  = mrtRun & mrtTick & (mrtCnt == 8'h01);

	// A zero count never runs, so the window opens at once
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mrtCnt  <= '0;
			mrtRun  <= 1'b0;
			mrtSlow <= 1'b0;
		end
		else if (mrtStart)
		begin
			mrtCnt  <= mrtCfg;
			mrtRun  <= (mrtCfg != 8'h00);
			mrtSlow <= ctrl.lpInitTarget;
		end
		else if (cmdClear | ctrl.lowPower | mrtExpire)
			mrtRun <= 1'b0;
		else if (mrtRun & mrtTick)
			mrtCnt <= mrtCnt - 8'h01;
	end

	// squelch only while masked, if enabled
	assign squelchOn = mrtRun & ctrl.squelchEn;

	// ----------------------------------------------------------------
	// No-response timer
	// ----------------------------------------------------------------
	logic [15:0] nrtCnt;
	logic        nrtRun;
	logic        nrtCoarse;

	wire [15:0] nrtCfg    = {nrtHi, nrtLo};
	wire        nrtTick   = nrtCoarse ? ticks.coarse : ticks.fine;
	// command ignored in active peer mode
	wire        nrtCmdOk  = cmdNrt & ~ctrl.p2pActive;
	// starts at end of transmit frame
	wire        nrtStart  = ~ctrl.lowPower & (ev.txEnd | nrtCmdOk);
	// peer field on plays the reply role in active peer mode
	wire        nrtStop   = nrtRun & ~ctrl.nrtEmv &
		(ctrl.p2pActive ? ev.peerFieldOn : ev.rxStart);
	wire        nrtClear  = cmdClear & ~ctrl.nrtEmv;
	wire        nrtExpire = nrtRun & nrtTick & (nrtCnt == 16'h0001) & ~nrtStop;
	// with unconditional expiry, window closes only if no reply is in progress
	wire        nrtForce  = nrtExpire & (~ctrl.nrtEmv | ~ev.replyActive);

	// Restart on a start while running; expiry before a stop in the same cycle is masked
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			nrtCnt    <= '0;
			nrtRun    <= 1'b0;
			nrtCoarse <= 1'b0;
		end
		else if (nrtStart)
		begin
			nrtCnt    <= nrtCfg;
			nrtRun    <= (nrtCfg != 16'h0000);
			nrtCoarse <= ctrl.nrtStep;
		end
		else if (nrtClear | ctrl.lowPower | nrtStop | nrtExpire)
			nrtRun <= 1'b0;
		else if (nrtRun & nrtTick)
			nrtCnt <= nrtCnt - 16'h0001;
	end

	// ----------------------------------------------------------------
	// General purpose timer
	// ----------------------------------------------------------------
	logic [15:0] gptCnt;
	logic        gptRun;

	wire gptTrig   = (ctrl.gptTrig == `RPT_GPT_TRIG_SOF)  ? ev.rxStart :
		(ctrl.gptTrig == `RPT_GPT_TRIG_EOF)  ? ev.rxEnd :
		(ctrl.gptTrig == `RPT_GPT_TRIG_FOFF) ? (ev.peerFieldOff & ctrl.p2pActive) :
		1'b0;
	wire gptStart  = ~ctrl.lowPower & (gptTrig | cmdGpt);
	wire gptExpire = gptRun & ticks.fine & (gptCnt == 16'h0001);

	// General timer counts in fine steps
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gptCnt <= '0;
			gptRun <= 1'b0;
		end
		else if (gptStart)
		begin
			gptCnt <= gptCfg;
			gptRun <= (gptCfg != 16'h0000);
		end
		else if (cmdClear | ctrl.lowPower | gptExpire)
			gptRun <= 1'b0;
		else if (gptRun & ticks.fine)
			gptCnt <= gptCnt - 16'h0001;
	end

	// ----------------------------------------------------------------
	// Wake-up timer
	// ----------------------------------------------------------------
	logic [7:0]     wutCnt;
	logic [WUW-1:0] wutDiv;
	logic           wutRun;

	wire wutStart  = cmdWut & ~ctrl.wakeMode;
	wire wutStep   = wutRun & (wutDiv == WUW'(WU_STEP_CYCLES - 1));
	wire wutExpire = wutStep & (wutCnt == 8'h01);

	// RC clock runs only while the timer does
	// keeps running in low power; Clear does not touch it
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wutCnt <= '0;
			wutDiv <= '0;
			wutRun <= 1'b0;
		end
		else if (wutStart)
		begin
			wutCnt <= wutCfg;
			wutDiv <= '0;
			wutRun <= 1'b1;
		end
		else if (wutExpire)
			wutRun <= 1'b0;
		else if (wutStep)
		begin
			wutCnt <= wutCnt - 8'h01;
			wutDiv <= '0;
		end
		else if (wutRun)
			wutDiv <= wutDiv + WUW'(1);
	end

	assign rcOscEn = wutRun;

	// ----------------------------------------------------------------
	// Receive window and status flags
	// ----------------------------------------------------------------
	logic nreFlag;
	logic gptFlag;
	logic wakeupExpiryFlag;

	// Window state: a fresh start outranks a close, which outranks an open
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			rxOn <= 1'b0;
		else if (mrtStart)
			rxOn <= (mrtCfg == 8'h00);
		else if (nrtForce)
			rxOn <= 1'b0;
		else if (mrtExpire)
			rxOn <= 1'b1;
	end

	// Flags are write-one-to-clear; a hit in the clear cycle stays set
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			nreFlag          <= 1'b0;
			gptFlag          <= 1'b0;
			wakeupExpiryFlag <= 1'b0;
		end
		else
		begin
			nreFlag          <= stickyNext(nreFlag, nrtExpire, flagClr & dat_i[0]);
			gptFlag          <= stickyNext(gptFlag, gptExpire, flagClr & dat_i[1]);
			wakeupExpiryFlag <= stickyNext(wakeupExpiryFlag, wutExpire,
				flagClr & dat_i[2]);
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	wire [31:0] statusWord = {24'h000000, wutRun, gptRun, nrtRun, mrtRun, rxOn,
		wakeupExpiryFlag, gptFlag, nreFlag};
	// Command register and unmapped addresses read as zero
	wire [31:0] rdMux =
		selCtrl   ? 32'(ctrl) :
		selMrt    ? 32'(mrtCfg) :
		selNrtHi  ? 32'(nrtHi) :
		selNrtLo  ? 32'(nrtLo) :
		selGpt    ? 32'(gptCfg) :
		selWut    ? 32'(wutCfg) :
		selStatus ? statusWord :
		32'h00000000;

	// Read data is captured together with ack
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			dat_o <= '0;
		else if (cyc_i & stb_i & ~ack_o & ~we_i)
			dat_o <= rdMux;
		else
			dat_o <= '0;
	end
endmodule

//--- sim/rpt_timers_properties.sv
// Port-level concurrent checks of the protocol timer unit
module rpt_timers_properties
	import rpt_pkg::*;
#(
	parameter int AW = 8
)
(
	input wire logic          clk_sys,
	input wire logic          arst_n,
	input wire logic          cyc_i,
	input wire logic          stb_i,
	input wire logic          we_i,
	input wire logic [AW-1:0] adr_i,
	input wire logic [31:0]   dat_i,
	input wire logic [3:0]    sel_i,
	input wire logic [31:0]   dat_o,
	input wire logic          ack_o,
	input wire logic          carrierTick,
	input wire rpt_evt_t      ev,
	input wire logic          rxOn,
	input wire logic          squelchOn,
	input wire logic          rcOscEn
);
	// ----------------------------------------
	// Shadow of control and mask count
	// ----------------------------------------
	logic [8:0] ctrl;
	logic [7:0] mrtCnt;
	wire        wrHit  = ack_o && cyc_i && stb_i && we_i;
	wire        wutCmd = wrHit && adr_i == 8'h18 && dat_i[7:0] == 8'h05;
	// A zero mask count or low power never starts the mask timer
	wire        mrtArm = mrtCnt != 8'h00 && !ctrl[3];

	// Follows software writes on the same edge the slave applies them
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl <= 9'h000;
			mrtCnt <= 8'h00;
		end
		else if (wrHit && adr_i == 8'h00)
			ctrl <= dat_i[8:0];
		else if (wrHit && adr_i == 8'h04)
			mrtCnt <= dat_i[7:0];
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_txend_closes_win: assert property (ev.txEnd && !ctrl[0] && mrtArm |=> !rxOn)
		else $error("window open after frame end");
	a_squelch_on_mask: assert property (ev.txEnd && !ctrl[0] && mrtArm && ctrl[4] |=> squelchOn)
		else $error("squelch off while masking");
	a_squelch_needs_en: assert property (!ctrl[4] |-> !squelchOn)
		else $error("squelch on while disabled");
	a_mask_blocks_rx: assert property (squelchOn |-> !rxOn)
		else $error("window open while masking");
	a_peer_starts_mask: assert property (ev.peerFieldOn && ctrl[0] && mrtArm |=> !rxOn)
		else $error("window open after peer field on");
	a_wake_only_cmd: assert property ($rose(rcOscEn) |-> $past(wutCmd))
		else $error("oscillator started without command");
	a_wake_refused: assert property (wutCmd && ctrl[2] && !rcOscEn |=> !rcOscEn)
		else $error("wake start accepted in wake mode");
	a_low_power_hold: assert property (ctrl[3] |=> !squelchOn)
		else $error("mask timer runs in low power");
	// Bus answer is a single cycle
	a_ack_one_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack not a one cycle answer");
	// Command register reads back zero
	a_cmd_reads_zero: assert property (ack_o && !we_i && adr_i == 8'h18 |-> dat_o == 32'h0)
		else $error("command register read nonzero");
endmodule

//--- sim/rpt_host_model.sv
// Bus master model of the controller that owns the register port
module rpt_host_model
(
	input  wire logic        clkSys,
	input  wire logic        ack,
	input  wire logic [31:0] rdat,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [31:0]      wdat,
	output logic [3:0]       sel
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus from time zero
	initial
	begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		sel = 4'h0;
	end

	// One classic cycle; the wait has no limit of its own, the bench watchdog ends a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clkSys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do
			@(posedge clkSys);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
endmodule

//--- sim/tb.sv
// Self-checking bench of the protocol timer unit
module tb
	import rpt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic        clkSys, arstN, cyc, stb, we, ack, carrierTick, rxOn, squelchOn, rcOscEn;
	logic [7:0]  adr, mrtN;
	logic [31:0] wdat, rdat, expV, q;
	logic [3:0]  sel;
	rpt_evt_t    ev;
	logic [31:0] expQ[$];
	int          nErrors, cmpCount;

	rpt_timers #(.AW(8), .WU_STEP_CYCLES(20)) u_dut (
		.clk_sys     (clkSys),
		.arst_n      (arstN),
		.cyc_i       (cyc),
		.stb_i       (stb),
		.we_i        (we),
		.adr_i       (adr),
		.dat_i       (wdat),
		.sel_i       (sel),
		.dat_o       (rdat),
		.ack_o       (ack),
		.carrierTick (carrierTick),
		.ev          (ev),
		.rxOn        (rxOn),
		.squelchOn   (squelchOn),
		.rcOscEn     (rcOscEn)
	);

	rpt_host_model u_host (.clkSys(clkSys), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb),
		.we(we), .adr(adr), .wdat(wdat), .sel(sel));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic tallyAndFinish();
		if (nErrors == 0 && cmpCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [31:0] e, input logic [31:0] g);
		cmpCount++;
		if (g !== e)
		begin
			nErrors++;
			$display("FAIL at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, q);
	endtask

	// Note the expectation first, the monitor takes it at the answer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		u_host.xfer(1'b0, a, 32'h0, q);
	endtask

	task automatic st(input logic [31:0] e);
		rd(8'h1c, e);
	endtask

	task automatic cmd(input logic [7:0] c);
		wr(8'h18, {24'h0, c});
	endtask

	// One-cycle event pulse; the reply level is left as it stands
	task automatic pulse(input rpt_evt_t p);
		@(posedge clkSys);
		ev <= ev | p;
		@(posedge clkSys);
		ev <= ev & 6'h04;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clkSys);
	endtask

	// ----------------------------------------
	// Clock, monitor and watchdog
	// ----------------------------------------
	initial
	begin
		clkSys = 1'b0;
		forever #50 clkSys = ~clkSys;
	end

	// Read data is compared against the oldest note at each read answer
	always @(posedge clkSys)
	begin
		if (ack === 1'b1 && we === 1'b0)
		begin
			expV = (expQ.size() != 0) ? expQ.pop_front() : 32'hx;
			check(expV, rdat);
		end
	end

	// The whole sequence needs about ten thousand cycles
	initial
	begin
		repeat (20000) @(posedge clkSys);
		nErrors++;
		tallyAndFinish();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		arstN = 1'b0;
		ev = '0;
		carrierTick = 1'b0;
		void'($urandom(47553));
		mrtN = 8'($urandom_range(4, 2));
		repeat (12) @(posedge clkSys);
		arstN <= 1'b1;
		carrierTick <= 1'b1;
		// reset values, unmapped place reads zero
		for (int a = 0; a <= 32; a += 4)
			rd(8'(a), (a == 20) ? 32'h0a : 32'h0);
		// frame end, mask then no-response expiry
		wr(8'h00, 32'h010);
		wr(8'h04, {24'h0, mrtN});
		wr(8'h0c, 32'h10);
		pulse(6'h20);
		st(32'h30);
		idle(64 * mrtN + 8);
		st(32'h28);
		idle(1100);
		st(32'h01);
		wr(8'h1c, 32'h07);
		st(32'h00);
		// restart, then reply start stops silently
		cmd(8'h03);
		idle(600);
		cmd(8'h03);
		idle(600);
		st(32'h20);
		pulse(6'h10);
		st(32'h00);
		wr(8'h00, 32'h120);
		wr(8'h10, 32'h10);
		pulse(6'h20);
		idle(64 * mrtN + 8);
		cmd(8'h04);
		st(32'h68);
		cmd(8'h01);
		st(32'h28);
		@(posedge clkSys);
		ev.replyActive <= 1'b1;
		idle(1100);
		st(32'h09);
		ev.replyActive <= 1'b0;
		wr(8'h1c, 32'h07);
		pulse(6'h08);
		st(32'h48);
		idle(1100);
		st(32'h0a);
		wr(8'h1c, 32'h07);
		wr(8'h00, 32'h001);
		cmd(8'h03);
		st(32'h08);
		pulse(6'h02);
		st(32'h10);
		idle(64 * mrtN + 8);
		pulse(6'h20);
		st(32'h28);
		idle(1100);
		st(32'h01);
		wr(8'h1c, 32'h07);
		// low power refusal, target mode 512 period mask step
		wr(8'h00, 32'h008);
		cmd(8'h04);
		cmd(8'h02);
		st(32'h00);
		wr(8'h00, 32'h002);
		cmd(8'h02);
		idle(64 * mrtN + 70);
		st(32'h10);
		idle(512 * mrtN);
		st(32'h08);
		wr(8'h00, 32'h004);
		cmd(8'h05);
		st(32'h08);
		wr(8'h00, 32'h000);
		wr(8'h14, 32'hff);
		rd(8'h14, 32'h50);
		wr(8'h14, 32'h03);
		cmd(8'h05);
		st(32'h88);
		idle(70);
		st(32'h0c);
		idle(4);
		tallyAndFinish();
	end
endmodule

bind rpt_timers rpt_timers_properties #(.AW(AW)) u_props (.clk_sys(clk_sys), .arst_n(arst_n),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
	.dat_o(dat_o), .ack_o(ack_o), .carrierTick(carrierTick), .ev(ev), .rxOn(rxOn),
	.squelchOn(squelchOn), .rcOscEn(rcOscEn));
